// ===== rtl/sms_regs.svh
`ifndef SMS_REGS_SVH
`define SMS_REGS_SVH

// Clock rate in kHz and timing figures in their own units.
`define SMS_CLK_KHZ 20000
`define SMS_FAIL_FILTER_NS 2000
`define SMS_FAIL_FILTER_CYC ((`SMS_FAIL_FILTER_NS * `SMS_CLK_KHZ) / 1000000 + 1)
`define SMS_SHORT_MS 4
`define SMS_SHORT_CYC (`SMS_SHORT_MS * `SMS_CLK_KHZ)
`define SMS_TOFF_MS 1000
`define SMS_TOFF_CYC (`SMS_TOFF_MS * `SMS_CLK_KHZ)
`define SMS_RETRY_WIN_MS 60000
`define SMS_RETRY_WIN_CYC (`SMS_RETRY_WIN_MS * `SMS_CLK_KHZ)
`define SMS_WAKE_PULSE_US 56
`define SMS_WAKE_PULSE_CYC (`SMS_WAKE_PULSE_US * `SMS_CLK_KHZ / 1000)
`define SMS_RETRY_LIMIT 4'h7

// Wake enable field positions and reset value.
`define SMS_WE_LIN 0
`define SMS_WE_CAN 1
`define SMS_WE_CONTACT 2
`define SMS_WE_TIMER 3
`define SMS_WE_DEFAULT 4'h7

`endif

// ===== rtl/sms_pkg.sv
package sms_pkg;
  typedef enum logic [1:0] {
    sms_active = 2'b00,
    sms_flash = 2'b01,
    sms_main_standby = 2'b10,
    sms_bat_standby = 2'b11
  } sms_mode_type;
endpackage

// ===== rtl/sms_reg_monitor.sv
`include "sms_regs.svh"

// Per-regulator fail latch and short-to-ground detector.
module sms_reg_monitor #(
  parameter int unsigned SHORT_CYC = `SMS_SHORT_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Regulator state.
  input wire logic enable,
  input wire logic below_fail,
  input wire logic clear_flags,
  // Results.
  output logic fail_flag,
  output logic short_flag,
  output logic short_off
);
  logic [7:0] filt_cnt;
  logic [31:0] on_cnt;
  logic was_up;
  logic enable_d;
  wire logic filt_done = (filt_cnt >= 8'(`SMS_FAIL_FILTER_CYC));
  wire logic turn_on = enable && !enable_d;
  wire logic short_hit = enable && !was_up && !short_off && (on_cnt >= SHORT_CYC - 1) && below_fail;

  // Dip filter: a fail needs the output low for longer than the filter time.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      filt_cnt <= 8'h00;
    end else if (!below_fail || !enable) begin
      filt_cnt <= 8'h00;
    end else if (!filt_done) begin
      filt_cnt <= filt_cnt + 8'h01;
    end
  end

  // Time since turn-on; short detection is armed until the output first rises.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      on_cnt <= 32'h0;
      was_up <= 1'b0;
      enable_d <= 1'b0;
    end else begin
      enable_d <= enable;
      if (turn_on) begin
        on_cnt <= 32'h0;
        was_up <= 1'b0;
      end else if (enable && on_cnt < SHORT_CYC) begin
        on_cnt <= on_cnt + 32'h1;
      end
      if (enable && !below_fail) begin
        was_up <= 1'b1;
      end
    end
  end

  // Flags hold through recovery; a new event wins over a clear.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fail_flag <= 1'b0;
      short_flag <= 1'b0;
      short_off <= 1'b0;
    end else begin
      if (filt_done || short_hit) begin
        fail_flag <= 1'b1;
      end else if (clear_flags) begin
        fail_flag <= 1'b0;
      end
      if (short_hit) begin
        short_flag <= 1'b1;
      end else if (clear_flags) begin
        short_flag <= 1'b0;
      end
      if (short_hit) begin
        short_off <= 1'b1;
      end else if (turn_on) begin
        short_off <= 1'b0;
      end
    end
  end
endmodule // sms_reg_monitor

// ===== rtl/sms_supervisor.sv
`include "sms_regs.svh"

module sms_supervisor #(
  parameter int unsigned SHORT_CYC = `SMS_SHORT_CYC,
  parameter int unsigned TOFF_CYC = `SMS_TOFF_CYC,
  parameter int unsigned RETRY_WIN_CYC = `SMS_RETRY_WIN_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Analog monitors.
  input wire logic thermal_stage_one,
  input wire logic thermal_stage_two,
  input wire logic main_below_fail,
  input wire logic aux_below_fail,
  input wire logic load_above_threshold,
  input wire logic lin_flash_level,
  input wire logic can_flash_level,
  // Controller commands, one-cycle pulses, with the wake enable value and the aux enable level.
  input wire logic cmd_clear_flags,
  input wire logic cmd_main_standby,
  input wire logic cmd_bat_standby,
  input wire logic cmd_write_wake_enable,
  input wire logic [3:0] cmd_wake_enable,
  input wire logic aux_enable_cfg,
  // Wake sources, one-cycle pulses.
  input wire logic lin_wake,
  input wire logic can_wake,
  input wire logic contact_wake,
  input wire logic spi_wake,
  input wire logic timer_wake,
  // Power controls.
  output logic main_regulator_on,
  output logic main_low_current,
  output logic aux_regulator_on,
  output logic outputs_enable,
  output logic relays_enable,
  output logic lin_tx_enable,
  output logic can_tx_enable,
  output logic watchdog_enable,
  output logic watchdog_long_window,
  // Status.
  output sms_pkg::sms_mode_type mode,
  output logic [3:0] wake_enable,
  output logic wake_interrupt_pin_n,
  output logic main_fail_flag,
  output logic aux_fail_flag,
  output logic aux_short_flag,
  output logic forced_standby_short_flag,
  output logic thermal_off_active,
  output logic [3:0] retry_count
);
  sms_pkg::sms_mode_type next_mode;
  logic [31:0] toff_cnt;
  logic [31:0] win_cnt;
  logic [10:0] pulse_cnt;
  logic main_short_off;
  logic aux_short_off;
  logic main_short_flag;
  logic flash_d;
  logic wd_long;
  logic hi_load;
  logic main_short_d;

  // A counter has expired once it reaches its limit less one; shared by the off timer and the window.
  function automatic logic count_expired(input logic [31:0] cnt, input logic [31:0] limit);
    return cnt >= limit - 32'h1;
  endfunction

  // Relays and the LIN transmitter share one gate: off in heat stage one and in either standby.
  function automatic logic link_drive_ok(input logic hot, input logic standby, input logic bat);
    return !hot && !standby && !bat;
  endfunction

  // Wake source qualification; the off timer masks every source.
  wire logic any_wake = !thermal_off_active && (
    (lin_wake && wake_enable[`SMS_WE_LIN]) ||
    (can_wake && wake_enable[`SMS_WE_CAN]) ||
    (contact_wake && wake_enable[`SMS_WE_CONTACT]) ||
    (timer_wake && wake_enable[`SMS_WE_TIMER]) ||
    spi_wake);
  // The controller keeps the two flash lines exclusive, so either one alone selects flash.
  wire logic flash_req = lin_flash_level || can_flash_level;
  wire logic in_standby = (mode == sms_pkg::sms_main_standby);
  wire logic in_bat = (mode == sms_pkg::sms_bat_standby);
  wire logic in_flash = (mode == sms_pkg::sms_flash);
  wire logic in_active = (mode == sms_pkg::sms_active);
  wire logic toff_done = thermal_off_active && count_expired(toff_cnt, TOFF_CYC);
  wire logic retry_fail = toff_done && thermal_stage_two;
  wire logic retry_limit = retry_fail && (retry_count >= `SMS_RETRY_LIMIT - 4'h1);
  // A main short forces standby once, on the cycle its flag rises; a level here would
  // hold the forced flag against the clear command and undo every later wake.
  wire logic main_short_event = main_short_flag && !main_short_d;
  wire logic force_bat = retry_limit || main_short_event;
  wire logic bad_wake_cfg = !cmd_wake_enable[`SMS_WE_TIMER] && !cmd_wake_enable[`SMS_WE_LIN] &&
    !cmd_wake_enable[`SMS_WE_CAN];
  wire logic wake_to_active = (in_standby || in_bat) && any_wake;
  // Regulator enables; a short keeps its regulator off until reset, since its short-off latch also holds the enable low.
  wire logic main_en = !thermal_off_active && !in_bat && !main_short_off;
  wire logic aux_en = aux_enable_cfg && !thermal_stage_one && !aux_short_off;

  // Regulator monitors, one per supply.
  // Each monitor owns its fail latch; the shared clear strobe is the only way back down.
  sms_reg_monitor #(.SHORT_CYC(SHORT_CYC)) u_main_mon (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(main_en),
    .below_fail(main_below_fail),
    .clear_flags(cmd_clear_flags),
    .fail_flag(main_fail_flag),
    .short_flag(main_short_flag),
    .short_off(main_short_off)
  );
  sms_reg_monitor #(.SHORT_CYC(SHORT_CYC)) u_aux_mon (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(aux_en),
    .below_fail(aux_below_fail),
    .clear_flags(cmd_clear_flags),
    .fail_flag(aux_fail_flag),
    .short_flag(aux_short_flag),
    .short_off(aux_short_off)
  );

  // Mode selection; forced battery standby has the highest priority.
  // Standby commands are honoured in active mode only, and flash entry goes before them.
  always_comb begin
    next_mode = mode;
    unique case (mode)
      sms_pkg::sms_active: begin
        if (flash_req) next_mode = sms_pkg::sms_flash;
        else if (cmd_bat_standby) next_mode = sms_pkg::sms_bat_standby;
        else if (cmd_main_standby) next_mode = sms_pkg::sms_main_standby;
      end
      sms_pkg::sms_flash: begin
        if (!flash_req) next_mode = sms_pkg::sms_active;
      end
      sms_pkg::sms_main_standby: begin
        if (wake_to_active) next_mode = sms_pkg::sms_active;
      end
      sms_pkg::sms_bat_standby: begin
        if (wake_to_active) next_mode = sms_pkg::sms_active;
      end
    endcase
    if (force_bat && !in_bat) next_mode = sms_pkg::sms_bat_standby;
  end

  // Mode register and the flash exit marker.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode <= sms_pkg::sms_active;
      flash_d <= 1'b0;
    end else begin
      mode <= next_mode;
      flash_d <= in_flash;
    end
  end

  // Delayed copy of the main short flag, so that the short is acted on as a single event.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      main_short_d <= 1'b0;
    end else begin
      main_short_d <= main_short_flag;
    end
  end

  // Wake enables; a deadlocking setting falls back to defaults.
  // Only the timer, LIN and CAN bits decide a deadlock, since contact wakes may never come.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wake_enable <= `SMS_WE_DEFAULT;
    end else if (cmd_write_wake_enable) begin
      wake_enable <= bad_wake_cfg ? `SMS_WE_DEFAULT : cmd_wake_enable;
    end
  end

  // Thermal off timer; runs on stage two and restarts the regulator at expiry.
  // It is not armed in battery standby, so a hot idle device stays quiet there.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      thermal_off_active <= 1'b0;
      toff_cnt <= 32'h0;
    end else if (!thermal_off_active) begin
      toff_cnt <= 32'h0;
      thermal_off_active <= thermal_stage_two && !in_bat;
    end else if (toff_done) begin
      toff_cnt <= 32'h0;
      thermal_off_active <= 1'b0;
    end else begin
      toff_cnt <= toff_cnt + 32'h1;
    end
  end

  // Restart failures counted over a one-minute window from the first failure.
  // The window restarts only when the count falls back to zero; failures are not aged singly.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      retry_count <= 4'h0;
      win_cnt <= 32'h0;
    end else if (retry_limit || cmd_clear_flags) begin
      retry_count <= 4'h0;
      win_cnt <= 32'h0;
    end else if (retry_fail) begin
      retry_count <= retry_count + 4'h1;
    end else if (retry_count != 4'h0) begin
      if (count_expired(win_cnt, RETRY_WIN_CYC)) begin
        retry_count <= 4'h0;
        win_cnt <= 32'h0;
      end else begin
        win_cnt <= win_cnt + 32'h1;
      end
    end
  end

  // Forced standby flag; a main short or the retry limit sets it.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      forced_standby_short_flag <= 1'b0;
    end else if (force_bat) begin
      forced_standby_short_flag <= 1'b1;
    end else if (cmd_clear_flags) begin
      forced_standby_short_flag <= 1'b0;
    end
  end

  // Wake pulse; a load-current rise never starts it.
  // It is started from main standby only; a wake out of battery standby raises no pulse.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pulse_cnt <= 11'h000;
    end else if (in_standby && any_wake) begin
      pulse_cnt <= 11'(`SMS_WAKE_PULSE_CYC);
    end else if (pulse_cnt != 11'h000) begin
      pulse_cnt <= pulse_cnt - 11'h001;
    end
  end

  // Standby load state and long watchdog window after flash exit or timer wake.
  // Load state is forced high outside standby, so entering standby starts at high current.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hi_load <= 1'b1;
      wd_long <= 1'b1;
    end else begin
      hi_load <= load_above_threshold || !in_standby;
      if ((flash_d && in_active) || (wake_to_active && timer_wake)) begin
        wd_long <= 1'b1;
      end else if (in_flash || in_bat) begin
        wd_long <= 1'b0;
      end
    end
  end

  // Output drive; high-side and aux keep their setup across main standby.
  // Every output is registered, so a mode change reaches the pins one cycle after the mode, or two for pins fed through hi_load or wd_long.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      main_regulator_on <= 1'b0;
      main_low_current <= 1'b0;
      aux_regulator_on <= 1'b0;
      outputs_enable <= 1'b0;
      relays_enable <= 1'b0;
      lin_tx_enable <= 1'b0;
      can_tx_enable <= 1'b0;
      watchdog_enable <= 1'b0;
      watchdog_long_window <= 1'b0;
      wake_interrupt_pin_n <= 1'b1;
    end else begin
      main_regulator_on <= main_en;
      main_low_current <= in_standby && !hi_load;
      aux_regulator_on <= aux_en && !in_bat;
      outputs_enable <= !thermal_stage_one && !in_bat;
      relays_enable <= link_drive_ok(thermal_stage_one, in_standby, in_bat);
      lin_tx_enable <= link_drive_ok(thermal_stage_one, in_standby, in_bat);
      can_tx_enable <= !in_standby && !in_bat;
      watchdog_enable <= in_active || (in_standby && hi_load);
      watchdog_long_window <= wd_long;
      wake_interrupt_pin_n <= !((in_standby && any_wake) || (pulse_cnt > 11'h001));
    end
  end
endmodule // sms_supervisor

// ===== tb/sms_mcu_model.sv
// Behavioural controller driving the flash lines and the flag clear command.
module sms_mcu_model (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Requests from the bench.
  input wire logic req_lin,
  input wire logic req_can,
  input wire logic req_clear,
  // Lines into the supervisor.
  output logic lin_flash_level,
  output logic can_flash_level,
  output logic cmd_clear_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  // Only one transmit line is ever lifted; LIN wins if both are asked for, so the supervisor never sees both.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lin_flash_level <= 1'b0;
      can_flash_level <= 1'b0;
      cmd_clear_flags <= 1'b0;
    end else begin
      lin_flash_level <= req_lin;
      can_flash_level <= req_can && !req_lin;
      cmd_clear_flags <= req_clear;
    end
  end
endmodule // sms_mcu_model

// ===== tb/sms_supervisor_props.sv
module sms_supervisor_props (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Watched inputs.
  input wire logic thermal_stage_one,
  input wire logic thermal_stage_two,
  input wire logic load_above_threshold,
  input wire logic lin_flash_level,
  input wire logic can_flash_level,
  input wire logic cmd_clear_flags,
  input wire logic cmd_write_wake_enable,
  input wire logic [3:0] cmd_wake_enable,
  input wire logic lin_wake,
  input wire logic can_wake,
  input wire logic contact_wake,
  input wire logic spi_wake,
  input wire logic timer_wake,
  // Watched outputs.
  input wire logic main_regulator_on,
  input wire logic aux_regulator_on,
  input wire logic outputs_enable,
  input wire logic lin_tx_enable,
  input wire logic watchdog_enable,
  input wire sms_pkg::sms_mode_type mode,
  input wire logic [3:0] wake_enable,
  input wire logic wake_interrupt_pin_n,
  input wire logic main_fail_flag,
  input wire logic thermal_off_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [10:0] low_cnt;
  wire any_wake = lin_wake | can_wake | contact_wake | timer_wake | spi_wake;
  wire no_flash = !lin_flash_level && !can_flash_level;
  // Counts low cycles of the wake pin so the pulse width can be judged when it ends.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset || wake_interrupt_pin_n) low_cnt <= 11'h000;
    else low_cnt <= low_cnt + 11'h001;
  end
  a_wake_default: assert property ($fell(reset) |-> wake_enable == 4'h7)
    else $error("wake enables wrong after reset");
  a_wake_reject: assert property (cmd_write_wake_enable && !cmd_wake_enable[3] && cmd_wake_enable[1:0] == 2'h0
    |=> wake_enable == 4'h7) else $error("dead wake setting accepted");
  a_stage_one_off: assert property (thermal_stage_one |=> !outputs_enable && !aux_regulator_on && !lin_tx_enable)
    else $error("outputs left on in stage one heat");
  a_stage_two_off: assert property ($rose(thermal_stage_two) && !thermal_off_active && mode != sms_pkg::sms_bat_standby
    |=> thermal_off_active ##1 !main_regulator_on) else $error("main not shut in stage two");
  a_off_ignores: assert property (thermal_off_active && mode == sms_pkg::sms_main_standby && any_wake && no_flash
    |=> mode == sms_pkg::sms_main_standby) else $error("wake taken during off time");
  a_pulse_width: assert property ($rose(wake_interrupt_pin_n) |-> low_cnt == 11'h460)
    else $error("wake pulse width wrong");
  a_load_silent: assert property (mode == sms_pkg::sms_main_standby && wake_interrupt_pin_n && load_above_threshold
    && !any_wake && no_flash && !thermal_off_active |=> wake_interrupt_pin_n && mode == sms_pkg::sms_main_standby)
    else $error("load rise woke device");
  a_lin_wake: assert property (mode == sms_pkg::sms_main_standby && lin_wake && wake_enable[0] && !thermal_off_active
    && no_flash |=> mode == sms_pkg::sms_active && !wake_interrupt_pin_n) else $error("lin wake missed");
  a_flash_entry: assert property (mode == sms_pkg::sms_active && (lin_flash_level ^ can_flash_level) && !thermal_stage_two
    |=> mode == sms_pkg::sms_flash) else $error("flash not entered");
  a_flash_wdog: assert property (mode == sms_pkg::sms_flash && $past(mode) == sms_pkg::sms_flash |-> !watchdog_enable)
    else $error("watchdog on in flash");
  a_fail_hold: assert property (main_fail_flag && !cmd_clear_flags |=> main_fail_flag)
    else $error("fail flag dropped uncleared");
endmodule // sms_supervisor_props

bind sms_supervisor sms_supervisor_props u_props (.*);

// ===== tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset, thermal_stage_one, thermal_stage_two, main_below_fail, aux_below_fail;
  logic load_above_threshold, cmd_main_standby, cmd_bat_standby, cmd_write_wake_enable, aux_enable_cfg;
  logic [3:0] cmd_wake_enable;
  logic [4:0] wk;
  logic req_lin, req_can, req_clear;
  wire logic lin_flash_level, can_flash_level, cmd_clear_flags, main_regulator_on, main_low_current;
  wire logic aux_regulator_on, outputs_enable, relays_enable, lin_tx_enable, can_tx_enable, watchdog_enable;
  wire logic watchdog_long_window, wake_interrupt_pin_n, main_fail_flag, aux_fail_flag, aux_short_flag;
  wire logic forced_standby_short_flag, thermal_off_active;
  wire sms_pkg::sms_mode_type mode;
  wire logic [3:0] wake_enable, retry_count;
  int fails, check_count, n;
  // Short counts keep the thermal and short timers quick in simulation.
  sms_supervisor #(.SHORT_CYC(50), .TOFF_CYC(200), .RETRY_WIN_CYC(5000)) u_dut (.*, .lin_wake(wk[0]),
    .can_wake(wk[1]), .contact_wake(wk[2]), .spi_wake(wk[3]), .timer_wake(wk[4]));
  sms_mcu_model u_mcu (.*);
  // Free-running 20 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task wt(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task ck(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task test_done;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task rst;
    @(posedge sys_clk) reset <= 1'b1;
    wt(4);
    @(posedge sys_clk) reset <= 1'b0;
    wt(1);
  endtask
  task clr;
    @(posedge sys_clk) req_clear <= 1'b1;
    @(posedge sys_clk) req_clear <= 1'b0;
    wt(3);
  endtask
  task wr(input logic [3:0] v);
    @(posedge sys_clk) cmd_write_wake_enable <= 1'b1;
    cmd_wake_enable <= v;
    @(posedge sys_clk) cmd_write_wake_enable <= 1'b0;
    wt(1);
  endtask
  task t_wake_cfg;
    ck(wake_enable === 4'h7 && mode === sms_pkg::sms_active && main_regulator_on === 1'b1, "reset state");
    wr(4'h4);
    ck(wake_enable === 4'h7, "dead wake set kept");
    wr(4'hf);
    ck(wake_enable === 4'hf, "wake set lost");
  endtask
  task t_flash;
    @(posedge sys_clk) req_lin <= 1'b1;
    wt(4);
    ck(mode === sms_pkg::sms_flash && watchdog_enable === 1'b0, "lin flash");
    @(posedge sys_clk) req_lin <= 1'b0;
    wt(4);
    ck(mode === sms_pkg::sms_active && watchdog_enable === 1'b1 && watchdog_long_window === 1'b1, "exit");
    @(posedge sys_clk) req_can <= 1'b1;
    wt(4);
    ck(mode === sms_pkg::sms_flash, "can flash");
    @(posedge sys_clk) req_can <= 1'b0;
    wt(4);
  endtask
  // Each wake source in turn from main standby; the first also sees a load rise.
  task t_wakes;
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk) cmd_main_standby <= 1'b1;
      @(posedge sys_clk) cmd_main_standby <= 1'b0;
      wt(2);
      ck(mode === sms_pkg::sms_main_standby && relays_enable === 1'b0 && lin_tx_enable === 1'b0
        && can_tx_enable === 1'b0 && main_regulator_on === 1'b1 && watchdog_enable === 1'b0
        && main_low_current === 1'b1, "standby");
      if (i == 0) begin
        @(posedge sys_clk) load_above_threshold <= 1'b1;
        wt(3);
        ck(mode === sms_pkg::sms_main_standby && wake_interrupt_pin_n === 1'b1 && watchdog_enable === 1'b1
          && main_low_current === 1'b0, "load rise");
        @(posedge sys_clk) load_above_threshold <= 1'b0;
        wt(2);
      end
      @(posedge sys_clk) wk <= 5'h01 << i;
      @(posedge sys_clk) wk <= 5'h00;
      #1;
      ck(mode === sms_pkg::sms_active && wake_interrupt_pin_n === 1'b0, "wake");
      n = 0;
      while (wake_interrupt_pin_n === 1'b0 && n < 1200) begin
        wt(1);
        n++;
      end
      ck(n == 1120, "pulse width");
    end
  endtask
  task t_fail;
    @(posedge sys_clk) main_below_fail <= 1'b1;
    wt(35);
    @(posedge sys_clk) main_below_fail <= 1'b0;
    wt(2);
    ck(main_fail_flag === 1'b0, "short dip latched");
    @(posedge sys_clk) main_below_fail <= 1'b1;
    wt(45);
    @(posedge sys_clk) main_below_fail <= 1'b0;
    wt(3);
    ck(main_fail_flag === 1'b1, "fail not held");
    clr();
    ck(main_fail_flag === 1'b0, "fail not cleared");
  endtask
  // A wake during the thermal off time is ignored; once the timer ends it is taken again.
  task t_off_wake;
    @(posedge sys_clk) cmd_main_standby <= 1'b1;
    @(posedge sys_clk) cmd_main_standby <= 1'b0;
    thermal_stage_two <= 1'b1;
    wt(3);
    @(posedge sys_clk) wk <= 5'h01;
    @(posedge sys_clk) wk <= 5'h00;
    thermal_stage_two <= 1'b0;
    wt(2);
    ck(mode === sms_pkg::sms_main_standby && wake_interrupt_pin_n === 1'b1 && thermal_off_active === 1'b1,
      "wake taken in off time");
    n = 0;
    while (thermal_off_active === 1'b1 && n < 400) begin
      wt(1);
      n++;
    end
    @(posedge sys_clk) wk <= 5'h01;
    @(posedge sys_clk) wk <= 5'h00;
    #1;
    ck(mode === sms_pkg::sms_active && wake_interrupt_pin_n === 1'b0, "no wake after off time");
  endtask
  task t_thermal;
    @(posedge sys_clk) thermal_stage_one <= 1'b1;
    wt(2);
    ck(outputs_enable === 1'b0 && aux_regulator_on === 1'b0 && lin_tx_enable === 1'b0
      && main_regulator_on === 1'b1, "stage one");
    @(posedge sys_clk) thermal_stage_two <= 1'b1;
    wt(2);
    ck(thermal_off_active === 1'b1 && main_regulator_on === 1'b0, "stage two");
    wt(148);
    @(posedge sys_clk) thermal_stage_two <= 1'b0;
    thermal_stage_one <= 1'b0;
    n = 0;
    while (thermal_off_active === 1'b1 && n < 400) begin
      wt(1);
      n++;
    end
    wt(3);
    ck(n >= 45 && n <= 55 && main_regulator_on === 1'b1, "restart");
    @(posedge sys_clk) thermal_stage_two <= 1'b1;
    n = 0;
    while (mode !== sms_pkg::sms_bat_standby && n < 3000) begin
      wt(1);
      n++;
    end
    ck(n >= 1300 && n <= 1600, "retry limit");
    @(posedge sys_clk) thermal_stage_two <= 1'b0;
    rst();
  endtask
  task t_shorts;
    @(posedge sys_clk) aux_enable_cfg <= 1'b1;
    wt(60);
    ck(aux_short_flag === 1'b1 && aux_fail_flag === 1'b1 && aux_regulator_on === 1'b0, "aux short");
    @(posedge sys_clk) aux_below_fail <= 1'b0;
    main_below_fail <= 1'b1;
    rst();
    wt(60);
    ck(forced_standby_short_flag === 1'b1 && main_fail_flag === 1'b1 && main_regulator_on === 1'b0
      && mode === sms_pkg::sms_bat_standby, "main short");
    @(posedge sys_clk) main_below_fail <= 1'b0;
    wt(2);
    ck(forced_standby_short_flag === 1'b1, "short flag dropped");
    clr();
    ck(forced_standby_short_flag === 1'b0 && main_fail_flag === 1'b0, "flags not cleared");
  endtask
  // Main sequence.
  initial begin
    {reset, aux_below_fail} = 2'h3;
    {thermal_stage_one, thermal_stage_two, main_below_fail, load_above_threshold} = 4'h0;
    {cmd_main_standby, cmd_bat_standby, cmd_write_wake_enable, aux_enable_cfg} = 4'h0;
    {cmd_wake_enable, wk, req_lin, req_can, req_clear} = 12'h000;
    wt(4);
    @(posedge sys_clk) reset <= 1'b0;
    wt(1);
    t_wake_cfg();
    t_flash();
    t_wakes();
    t_fail();
    t_off_wake();
    t_thermal();
    t_shorts();
    test_done();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    $display("[FAIL] %0t timeout", $time);
    test_done();
  end
endmodule // testbench
